//--- design/clpr_consts.vh
/*
 * offsets, field positions, reset values and encodings of the
 * cache lock and partition register bank.
 * assumes: included by the bank module, its property checker and its bench, byte addresses on a 32-bit bus.
 */
`ifndef CLPR_CONSTS_VH
`define CLPR_CONSTS_VH

// byte offsets, each 64-bit register spans two words (low word first)
`define CLPR_OFS_WAYS        12'hc00
`define CLPR_OFS_REGION_TWO_START_ADDR       12'hc18
`define CLPR_OFS_REGION_THREE_START_ADDR       12'hc20
`define CLPR_OFS_IO_MASK     12'hc28
`define CLPR_OFS_DMA_MASK    12'hc30
`define CLPR_OFS_COH_LOW     12'hc38
`define CLPR_OFS_COH_HIGH    12'hc40
`define CLPR_OFS_PART0       12'hc48
`define CLPR_OFS_PART1       12'hc50

// base register layout
`define CLPR_VALID_BIT       63
`define CLPR_ADDR_MSB        51
`define CLPR_BASE_RW_MASK    64'h800f_ffff_ffff_ffff

// reset values
`define CLPR_BASE_RST        64'h0000_0000_0000_0000
`define CLPR_MASK32_RST      32'h0000_0000
`define CLPR_MASK64_RST      64'h0000_0000_0000_0000
`define CLPR_PART_RST        64'hffff_ffff_ffff_ffff
`define CLPR_WAYS_RST        4'h0

// requester classes on the allocation query port
`define CLPR_CLS_IO          2'h0
`define CLPR_CLS_DMA         2'h1
`define CLPR_CLS_COH         2'h2

`endif

//--- design/clpr_bank.v
/*
 * cache lock and partition configuration bank with an ahb-lite slave
 * and a registered allocation query port.
 * assumes: single word transfers only, one master, hnonsec from an ahb5
 * style fabric, allocation query inputs synchronous to hclk.
 */
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ps
`include "clpr_consts.vh"

module clpr_bank #(
   parameter ID_W = 7
) (
   input  wire              hclk,
   input  wire              hresetn,
   input  wire              hsel,
   input  wire [31:0]       haddr,
   input  wire [1:0]        htrans,
   input  wire              hwrite,
   input  wire [2:0]        hsize,
   input  wire [31:0]       hwdata,
   input  wire              hready,
   input  wire              hnonsec,
   output reg  [31:0]       hrdata,
   output reg               hreadyout,
   output reg               hresp,
   input  wire              alloc_valid,
   input  wire [1:0]        alloc_class,
   input  wire [ID_W-1:0]   alloc_id,
   output reg               alloc_rsp_valid,
   output reg               alloc_to_lock,
   output reg               part0_allow,
   output reg               part1_allow,
   output reg  [15:0]       locked_way_mask,
   output reg               region_two_valid_flag,
   output reg  [51:0]       region_two_start_addr,
   output reg               region_three_valid_flag,
   output reg  [51:0]       region_three_start_addr
);

   // register storage
   reg  [3:0]   ways_reg;
   reg  [63:0]  region_two_start_addr_reg;
   reg  [63:0]  region_three_start_addr_reg;
   reg  [31:0]  io_mask_reg;
   reg  [31:0]  dma_mask_reg;
   reg  [63:0]  coh_low_reg;
   reg  [63:0]  coherent_lock_bits_high;
   reg  [63:0]  partition_zero_allow_bits;
   reg  [63:0]  partition_one_allow_bits;

   // captured address phase
   reg          wr_pend_reg;
   reg          rd_pend_reg;
   reg  [11:0]  addr_reg;
   reg          sec_reg;

   wire         take;
   wire [11:0]  wofs;

   // merge a word into one half of a 64-bit register
   function [63:0] put_half;
      input [63:0] old;
      input        hi;
      input [31:0] d;
      begin
         put_half = hi ? {d, old[31:0]} : {old[63:32], d};
      end
   endfunction

   // only the encodings of 1, 2, 4, 8 and 12 ways are accepted
   function legal_ways;
      input [3:0] w;
      begin
         legal_ways = (w == 4'h1) || (w == 4'h2) || (w == 4'h4) ||
                      (w == 4'h8) || (w == 4'hc);
      end
   endfunction

   // 64-bit register (8-byte) aligned offset with the half select dropped
   function [11:0] reg_base;
      input [11:0] a;
      begin
         reg_base = {a[11:3], 3'h0};
      end
   endfunction

   // secure-only register decode
   function sec_only;
      input [11:0] a;
      begin
         sec_only = (reg_base(a) == `CLPR_OFS_WAYS) || (reg_base(a) == `CLPR_OFS_REGION_TWO_START_ADDR) ||
                    (reg_base(a) == `CLPR_OFS_REGION_THREE_START_ADDR) || (reg_base(a) == `CLPR_OFS_IO_MASK);
      end
   endfunction

   // read mux, reserved bits and blocked secure reads give zero
   function [31:0] rd_word;
      input [11:0] a;
      input        sec;
      reg   [63:0] v;
      begin
         v = 64'h0;
         case (reg_base(a))
            `CLPR_OFS_WAYS:     v = {60'h0, ways_reg};
            `CLPR_OFS_REGION_TWO_START_ADDR:    v = region_two_start_addr_reg & `CLPR_BASE_RW_MASK;
            `CLPR_OFS_REGION_THREE_START_ADDR:    v = region_three_start_addr_reg & `CLPR_BASE_RW_MASK;
            `CLPR_OFS_IO_MASK:  v = {32'h0, io_mask_reg};
            `CLPR_OFS_DMA_MASK: v = {32'h0, dma_mask_reg};
            `CLPR_OFS_COH_LOW:  v = coh_low_reg;
            `CLPR_OFS_COH_HIGH: v = coherent_lock_bits_high;
            `CLPR_OFS_PART0:    v = partition_zero_allow_bits;
            `CLPR_OFS_PART1:    v = partition_one_allow_bits;
            default:            v = 64'h0;
         endcase
         if (sec_only(a) && !sec)
            v = 64'h0;
         rd_word = a[2] ? v[63:32] : v[31:0];
      end
   endfunction

   assign take    = hsel & hready & htrans[1];
   assign wofs    = reg_base(addr_reg);

   // ahb slave control: writes are zero-wait, reads insert one wait state
   // so that hrdata comes straight from a flop and sees any write just done
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         addr_reg    <= 12'h000;
         sec_reg     <= 1'b0;
         hreadyout   <= 1'b1;
         hresp       <= 1'b0;
         hrdata      <= 32'h0000_0000;
      end else begin
         hresp <= 1'b0;                  // always okay
         if (rd_pend_reg) begin
            hrdata      <= rd_word(addr_reg, sec_reg);
            hreadyout   <= 1'b1;
            rd_pend_reg <= 1'b0;
         end else if (hreadyout) begin
            wr_pend_reg <= take & hwrite;
            rd_pend_reg <= take & ~hwrite;
            hreadyout   <= ~(take & ~hwrite);
            if (take) begin
               addr_reg <= haddr[11:0];
               sec_reg  <= ~hnonsec;
            end
         end
      end
   end

   // next register values: hold by default, take the data-phase word of an
   // accepted write; a blocked secure write leaves every register untouched
   reg  [3:0]   ways_next;
   reg  [63:0]  region_two_start_addr_next;
   reg  [63:0]  region_three_start_addr_next;
   reg  [31:0]  io_mask_next;
   reg  [31:0]  dma_mask_next;
   reg  [63:0]  coh_low_next;
   reg  [63:0]  coherent_lock_bits_high_next;
   reg  [63:0]  partition_zero_allow_bits_next;
   reg  [63:0]  partition_one_allow_bits_next;
   reg          wr_ok;

   // write decode in the data phase, where hwdata stands
   always @* begin
      ways_next                      = ways_reg;
      region_two_start_addr_next                     = region_two_start_addr_reg;
      region_three_start_addr_next                     = region_three_start_addr_reg;
      io_mask_next                   = io_mask_reg;
      dma_mask_next                  = dma_mask_reg;
      coh_low_next                   = coh_low_reg;
      coherent_lock_bits_high_next   = coherent_lock_bits_high;
      partition_zero_allow_bits_next = partition_zero_allow_bits;
      partition_one_allow_bits_next  = partition_one_allow_bits;
      wr_ok                          = wr_pend_reg && (sec_reg || !sec_only(addr_reg));
      if (wr_ok) begin
         case (wofs)
            `CLPR_OFS_WAYS:
               if (!addr_reg[2] && legal_ways(hwdata[3:0]))
                  ways_next = hwdata[3:0];
            `CLPR_OFS_REGION_TWO_START_ADDR:
               region_two_start_addr_next = put_half(region_two_start_addr_reg, addr_reg[2], hwdata) & `CLPR_BASE_RW_MASK;
            `CLPR_OFS_REGION_THREE_START_ADDR:
               region_three_start_addr_next = put_half(region_three_start_addr_reg, addr_reg[2], hwdata) & `CLPR_BASE_RW_MASK;
            `CLPR_OFS_IO_MASK:
               if (!addr_reg[2])
                  io_mask_next = hwdata;
            `CLPR_OFS_DMA_MASK:
               if (!addr_reg[2])
                  dma_mask_next = hwdata;
            `CLPR_OFS_COH_LOW:
               coh_low_next = put_half(coh_low_reg, addr_reg[2], hwdata);
            `CLPR_OFS_COH_HIGH:
               coherent_lock_bits_high_next = put_half(coherent_lock_bits_high, addr_reg[2], hwdata);
            `CLPR_OFS_PART0:
               partition_zero_allow_bits_next = put_half(partition_zero_allow_bits, addr_reg[2], hwdata);
            `CLPR_OFS_PART1:
               partition_one_allow_bits_next = put_half(partition_one_allow_bits, addr_reg[2], hwdata);
            default: ;
         endcase
      end
   end

   // register flops, loaded every cycle from the next values
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ways_reg                  <= `CLPR_WAYS_RST;
         region_two_start_addr_reg                 <= `CLPR_BASE_RST;
         region_three_start_addr_reg                 <= `CLPR_BASE_RST;
         io_mask_reg               <= `CLPR_MASK32_RST;
         dma_mask_reg              <= `CLPR_MASK32_RST;
         coh_low_reg               <= `CLPR_MASK64_RST;
         coherent_lock_bits_high   <= `CLPR_MASK64_RST;
         partition_zero_allow_bits <= `CLPR_PART_RST;
         partition_one_allow_bits  <= `CLPR_PART_RST;
      end else begin
         ways_reg                  <= ways_next;
         region_two_start_addr_reg                 <= region_two_start_addr_next;
         region_three_start_addr_reg                 <= region_three_start_addr_next;
         io_mask_reg               <= io_mask_next;
         dma_mask_reg              <= dma_mask_next;
         coh_low_reg               <= coh_low_next;
         coherent_lock_bits_high   <= coherent_lock_bits_high_next;
         partition_zero_allow_bits <= partition_zero_allow_bits_next;
         partition_one_allow_bits  <= partition_one_allow_bits_next;
      end
   end

   // selected requester's lock bit for the query
   reg          lock_bit;
   reg          coh_low_id;
   always @* begin
      coh_low_id = (alloc_id[ID_W-1:6] == {(ID_W-6){1'b0}});
      case (alloc_class)
         `CLPR_CLS_IO:  lock_bit = (alloc_id[ID_W-1:5] == {(ID_W-5){1'b0}}) & io_mask_reg[alloc_id[4:0]];
         `CLPR_CLS_DMA: lock_bit = (alloc_id[ID_W-1:5] == {(ID_W-5){1'b0}}) & dma_mask_reg[alloc_id[4:0]];
         `CLPR_CLS_COH: lock_bit = coh_low_id ? coh_low_reg[alloc_id[5:0]]
                                              : coherent_lock_bits_high[alloc_id[5:0]];
         default:       lock_bit = 1'b0;
      endcase
   end

   // way count as a mask of the low ways, zero until a legal count is set
   function [15:0] way_mask;
      input [3:0] w;
      begin
         case (w)
            4'h1:    way_mask = 16'h0001;
            4'h2:    way_mask = 16'h0003;
            4'h4:    way_mask = 16'h000f;
            4'h8:    way_mask = 16'h00ff;
            4'hc:    way_mask = 16'h0fff;
            default: way_mask = 16'h0000;
         endcase
      end
   endfunction

   // registered query answer and exported region settings; partition
   // permission speaks only of new allocations, hits never consult it
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         alloc_rsp_valid         <= 1'b0;
         alloc_to_lock           <= 1'b0;
         part0_allow             <= 1'b0;
         part1_allow             <= 1'b0;
         locked_way_mask         <= 16'h0000;
         region_two_valid_flag   <= 1'b0;
         region_two_start_addr   <= 52'h0;
         region_three_valid_flag <= 1'b0;
         region_three_start_addr <= 52'h0;
      end else begin
         alloc_rsp_valid <= alloc_valid;
         alloc_to_lock   <= alloc_valid & lock_bit & (ways_reg != 4'h0) &
                            (region_two_start_addr_reg[`CLPR_VALID_BIT] | region_three_start_addr_reg[`CLPR_VALID_BIT]);
         part0_allow     <= alloc_valid & (alloc_class == `CLPR_CLS_COH) & coh_low_id &
                            partition_zero_allow_bits[alloc_id[5:0]];
         part1_allow     <= alloc_valid & (alloc_class == `CLPR_CLS_COH) & coh_low_id &
                            partition_one_allow_bits[alloc_id[5:0]];
         locked_way_mask <= way_mask(ways_reg);
         // clearing valid keeps the stored base untouched
         region_two_valid_flag   <= region_two_start_addr_reg[`CLPR_VALID_BIT];
         region_two_start_addr   <= region_two_start_addr_reg[`CLPR_ADDR_MSB:0];
         region_three_valid_flag <= region_three_start_addr_reg[`CLPR_VALID_BIT];
         region_three_start_addr <= region_three_start_addr_reg[`CLPR_ADDR_MSB:0];
      end
   end

endmodule

//--- dv/clpr_bank_properties.sv
/* port checker for the lock and partition bank.
   assumes: bound to clpr_bank, one clock, hready looped from hreadyout. */
`timescale 1ns/1ps
`include "clpr_consts.vh"
module clpr_bank_properties #(parameter ID_W = 7) (
   input wire            hclk,
   input wire            hresetn,
   input wire            hsel,
   input wire [1:0]      htrans,
   input wire            hwrite,
   input wire            hready,
   input wire            hreadyout,
   input wire            hresp,
   input wire            alloc_valid,
   input wire [1:0]      alloc_class,
   input wire [ID_W-1:0] alloc_id,
   input wire            alloc_rsp_valid,
   input wire            alloc_to_lock,
   input wire            part0_allow,
   input wire            part1_allow,
   input wire [15:0]     locked_way_mask
);
   // accepted transfer, reads pay one wait state
   wire req = hsel && hready && htrans[1] && hreadyout;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_read_one_wait: assert property (req && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   a_write_no_wait: assert property (req && hwrite |=> hreadyout)
      else $error("write stalled");
   a_resp_okay: assert property (!hresp)
      else $error("error response seen");
   a_rsp_follows: assert property (alloc_valid |=> alloc_rsp_valid)
      else $error("query answer missing");
   a_lock_has_rsp: assert property (alloc_to_lock |-> alloc_rsp_valid)
      else $error("lock without query");
   a_part_class: assert property (alloc_valid && alloc_class != `CLPR_CLS_COH |=> !part0_allow && !part1_allow)
      else $error("partition grant to other class");
   a_part_id_range: assert property (alloc_valid && (alloc_id[ID_W-1:6] != 0) |=> !part0_allow && !part1_allow)
      else $error("partition grant beyond id 63");
   a_way_mask_legal: assert property (locked_way_mask inside {16'h0, 16'h1, 16'h3, 16'hf, 16'hff, 16'hfff})
      else $error("locked way mask illegal");
   c_read: cover property (req && !hwrite);
   c_write: cover property (req && hwrite);
   c_lock: cover property (alloc_to_lock);
   c_part: cover property (part0_allow && part1_allow);
endmodule
bind clpr_bank clpr_bank_properties #(.ID_W(ID_W)) clpr_bank_properties_inst (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .alloc_valid(alloc_valid), .alloc_class(alloc_class), .alloc_id(alloc_id), .alloc_rsp_valid(alloc_rsp_valid),
   .alloc_to_lock(alloc_to_lock), .part0_allow(part0_allow), .part1_allow(part1_allow),
   .locked_way_mask(locked_way_mask));

//--- dv/clpr_bank_tb.sv
/* self-checking bench for the lock and partition bank.
   assumes: one ahb-lite master, hready looped from hreadyout. */
`timescale 1ns/1ps
`include "clpr_consts.vh"
module clpr_bank_tb;
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hnonsec = 0, alloc_valid = 0, rd_pend = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata;
   logic [1:0]  htrans = 0, alloc_class = 0;
   logic [6:0]  alloc_id = 0;
   logic        hreadyout, hresp, alloc_rsp_valid, alloc_to_lock, part0_allow, part1_allow;
   logic        region_two_valid_flag, region_three_valid_flag;
   logic [51:0] region_two_start_addr, region_three_start_addr;
   logic [15:0] locked_way_mask;
   logic [31:0] m [0:23];
   logic [31:0] rq [$];
   logic [31:0] qq [$];
   int          error_cnt = 0, checks_done = 0;

   clpr_bank clpr_bank_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hnonsec(hnonsec), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .alloc_valid(alloc_valid), .alloc_class(alloc_class),
      .alloc_id(alloc_id), .alloc_rsp_valid(alloc_rsp_valid), .alloc_to_lock(alloc_to_lock),
      .part0_allow(part0_allow), .part1_allow(part1_allow), .locked_way_mask(locked_way_mask),
      .region_two_valid_flag(region_two_valid_flag), .region_two_start_addr(region_two_start_addr),
      .region_three_valid_flag(region_three_valid_flag), .region_three_start_addr(region_three_start_addr));

   initial forever #20 hclk = ~hclk;

   task check(input logic [63:0] seen, input logic [63:0] exp, input string nm);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task print_verdict;
      if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // word index i is offset c00 + 4*i; model updated when the request is issued
   task xfer(input bit w, input int i, input logic [31:0] d, input bit ns);
      bit sec;
      sec = i == 0 || (i >= 6 && i <= 11);
      hsel <= 1;
      htrans <= 2'h2;
      hwrite <= w;
      hnonsec <= ns;
      haddr <= {20'h0, `CLPR_OFS_WAYS} + 32'(i * 4);
      if (!w) rq.push_back(ns && sec ? 32'h0 : m[i]);
      else if (!(ns && sec) && !(i inside {[1:5], 11, 13, 22, 23})) begin
         if (i != 0) m[i] = d & (i == 7 || i == 9 ? 32'h800f_ffff : 32'hffff_ffff);
         else if (d inside {1, 2, 4, 8, 12}) m[i] = d;
      end
      do @(posedge hclk); while (!hreadyout);
      htrans <= 2'h0;
      hsel <= 0;
      hwdata <= d;
      do @(posedge hclk); while (!hreadyout);
   endtask

   // expected {lock, part0, part1} for one query
   function logic [31:0] qexp(input logic [1:0] c, input logic [6:0] id);
      logic b;
      b = c == 0 ? id < 32 && m[10][id[4:0]] : c == 1 ? id < 32 && m[12][id[4:0]] : c == 2 && m[14 + id[6:5]][id[4:0]];
      return {b && (m[0] inside {1, 2, 4, 8, 12}) && (m[7][31] || m[9][31]),
         c == 2 && !id[6] && m[18 + id[5]][id[4:0]], c == 2 && !id[6] && m[20 + id[5]][id[4:0]]};
   endfunction

   // result watcher, pops the oldest note as each answer appears
   always @(posedge hclk) begin
      if (rd_pend && hreadyout) check(hrdata, rq.pop_front(), "hrdata");
      if (alloc_rsp_valid) check({alloc_to_lock, part0_allow, part1_allow}, qq.pop_front(), "query");
      if (hsel && htrans[1] && hreadyout) rd_pend <= !hwrite;
      else if (hreadyout) rd_pend <= 0;
   end

   initial begin
      logic [1:0]  c;
      logic [6:0]  id;
      logic [31:0] wv [0:5];
      wv = '{1, 2, 4, 8, 12, 3};
      id = 7'($urandom(24));
      foreach (m[i]) m[i] = i >= 18 && i <= 21 ? 32'hffff_ffff : 32'h0;
      repeat (16) @(posedge hclk);
      hresetn <= 1;
      @(posedge hclk);
      // the last pass reads back and queries but writes nothing, so the final writes are checked too
      for (int p = 0; p < 7; p++) begin
         for (int i = 0; i < 24; i++) xfer(0, i, $urandom, 1'($urandom));
         repeat (2) @(posedge hclk);
         check(locked_way_mask, m[0] inside {1, 2, 4, 8, 12} ? (16'h1 << m[0][3:0]) - 1 : 0, "ways");
         check({region_two_valid_flag, region_two_start_addr}, {m[7][31], m[7][19:0], m[6]}, "region_two_start_addr");
         check({region_three_valid_flag, region_three_start_addr}, {m[9][31], m[9][19:0], m[8]}, "region_three_start_addr");
         // back-to-back queries, random classes and ids
         for (int k = 0; k < 48; k++) begin
            c = 2'($urandom);
            id = 7'($urandom);
            alloc_valid <= 1;
            alloc_class <= c;
            alloc_id <= id;
            qq.push_back(qexp(c, id));
            @(posedge hclk);
         end
         // queries stop before the base writes, standing in for the flush and
         // the quiet gap; range locking and on-chip memory mode stay off
         alloc_valid <= 0;
         if (p < 6)
            for (int i = 0; i < 24; i++) xfer(1, i, i == 0 ? wv[p] : $urandom, i == 0 ? 1'b0 : 1'($urandom));
      end
      repeat (3) @(posedge hclk);
      check(rq.size() + qq.size(), 0, "notes left");
      print_verdict();
   end

   // hang guard at 20000 cycles, the run needs about twelve hundred cycles
   initial begin
      #(40 * 20000);
      error_cnt++;
      print_verdict();
   end
endmodule
